// File: hw/hmi_consts.svh
// Constants for the host microport: widths, mode codes and timing counts.
// Assumes inclusion from the package and from both end modules.
`ifndef HMI_CONSTS_SVH
`define HMI_CONSTS_SVH
`define HMI_DATA_W 8
`define HMI_ADDR_W 3
`define HMI_SEL_W 4
`define HMI_LOCS 8
`define HMI_CTRL_ADDR 3'h7
`define HMI_SEL_HI 5
`define HMI_SEL_LO 2
`define HMI_MODE_PAIR 1'h0
`define HMI_MODE_DIR 1'h1
`define HMI_ACC_MAX_CLK 13
`define HMI_RD_WAIT 4'h4
`define HMI_CNT_W 4
`define HMI_RESET_BYTE 8'h00
`endif

// File: hw/hmi_pkg.sv
// Types shared by both ends of the host microport.
// Assumes hmi_consts.svh is on the include path.
`include "hmi_consts.svh"
package hmi_pkg;
   // Device port sequencer
   typedef enum logic [1:0] {hmi_dev_idle, hmi_dev_wait, hmi_dev_ack, hmi_dev_done} hmi_dev_state_t;
   // Host port sequencer
   typedef enum logic [2:0] {hmi_host_idle, hmi_host_setup, hmi_host_strobe, hmi_host_hold,
      hmi_host_end} hmi_host_state_t;
endpackage

// File: hw/hmi_bus_if.sv
// Interface carrying the 8-bit microport pins between host and device.
// The interface itself resolves the data wire from the two enables.
`timescale 1ns/10ps
`default_nettype none
`include "hmi_consts.svh"
interface hmi_bus_if;
   // Mode and address
   logic mode;
   logic [`HMI_ADDR_W-1:0] addr;
   logic [`HMI_SEL_W-1:0] device_select_code;
   // Select and strobes active low; dir_pin high reads in direction-line, ready high in strobe-pair
   logic chip_sel_n;
   logic host_strobe_pin;
   logic dir_pin;
   logic host_acknowledge_pin;
   // Data bus: value and enable per driver, then the shared wire
   logic [`HMI_DATA_W-1:0] host_data_out;
   logic host_data_oe;
   logic [`HMI_DATA_W-1:0] dev_data_out;
   logic dev_data_oe;
   logic [`HMI_DATA_W-1:0] data_wire;
   // Wire level worked out from the enables
   assign data_wire = dev_data_oe ? dev_data_out :
      (host_data_oe ? host_data_out : {`HMI_DATA_W{1'b1}});
   modport device (input mode, addr, device_select_code, chip_sel_n, host_strobe_pin, dir_pin,
      data_wire, output host_acknowledge_pin, dev_data_out, dev_data_oe);
   modport host (output mode, addr, chip_sel_n, host_strobe_pin, dir_pin, host_data_out,
      host_data_oe, input host_acknowledge_pin, data_wire);
endinterface
`default_nettype wire

// File: hw/hmi_device.sv
// Device end of the host microport: eight byte locations behind a 3-bit address.
// Assumes pins come from another domain; each passes two flip-flops first.
`timescale 1ns/10ps
`default_nettype none
`include "hmi_consts.svh"
module hmi_device
   import hmi_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins toward the host
   hmi_bus_if.device bus,
   // User side: view of the location file
   output logic [`HMI_DATA_W-1:0] ctrl_byte,
   output logic write_seen
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two stages each
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [`HMI_ADDR_W-1:0] addr1, addr2;
   logic [`HMI_SEL_W-1:0] sel1, sel2;
   logic [`HMI_DATA_W-1:0] din1, din2;
   logic [4:0] next_sync1;
   always_comb begin
      next_sync1 = {bus.mode, bus.chip_sel_n, bus.host_strobe_pin, bus.dir_pin, 1'b0};
   end
   // Register the raw pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 5'h0e;
         sync2 <= 5'h0e;
         addr1 <= '0;
         addr2 <= '0;
         sel1 <= '0;
         sel2 <= '0;
         din1 <= '0;
         din2 <= '0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= sync1;
         addr1 <= bus.addr;
         addr2 <= addr1;
         sel1 <= bus.device_select_code;
         sel2 <= sel1;
         din1 <= bus.data_wire;
         din2 <= din1;
      end
   end
   // Synchronised pin views
   logic s_mode, s_cs_n, s_strobe, s_dir;
   assign s_mode = sync2[4];
   assign s_cs_n = sync2[3];
   assign s_strobe = sync2[2];
   assign s_dir = sync2[1];
   ////////////////////////////////////////////////////////////////////////////
   // Decode of the access in the chosen convention
   logic [`HMI_DATA_W-1:0] locs [`HMI_LOCS];
   logic sel_match, rd_req, wr_req;
   always_comb begin
      // Extra devices on the bus stay silent unless the code matches
      sel_match = (sel2 == locs[`HMI_CTRL_ADDR][`HMI_SEL_HI:`HMI_SEL_LO]);
      if (s_mode == `HMI_MODE_DIR) begin
         // Data strobe qualifies, direction pin high reads
         rd_req = !s_strobe && s_dir;
         wr_req = !s_strobe && !s_dir;
      end else begin
         // Separate read and write strobes
         rd_req = !s_strobe;
         wr_req = !s_dir;
      end
      rd_req = rd_req && !s_cs_n && sel_match;
      wr_req = wr_req && !s_cs_n && sel_match;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer
   hmi_dev_state_t state, next_state;
   logic [`HMI_CNT_W-1:0] cnt, next_cnt;
   logic ack, next_ack;
   logic oe, next_oe;
   logic [`HMI_DATA_W-1:0] dout, next_dout;
   logic wr_en;
   logic next_write_seen;
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_dout = dout;
      next_oe = oe && !s_cs_n && rd_req;
      wr_en = 1'b0;
      next_write_seen = 1'b0;
      unique case (state)
         hmi_dev_idle: begin
            next_cnt = '0;
            if (rd_req) begin
               next_state = hmi_dev_wait;
            end else if (wr_req) begin
               // Store once per strobe
               wr_en = 1'b1;
               next_write_seen = 1'b1;
               next_state = hmi_dev_ack;
            end
         end
         hmi_dev_wait: begin
            // Fixed latency well inside the 13-clock access limit
            next_cnt = cnt + 1'b1;
            if (!rd_req) begin
               next_state = hmi_dev_idle;
            end else if (cnt == `HMI_RD_WAIT) begin
               next_dout = locs[addr2];
               next_oe = 1'b1;
               next_state = hmi_dev_ack;
            end
         end
         hmi_dev_ack: begin
            // Hold the acknowledge until the strobe ends
            if (!rd_req && !wr_req) begin
               next_state = hmi_dev_done;
            end
         end
         hmi_dev_done: begin
            next_state = hmi_dev_idle;
         end
      endcase
      // Acknowledge pin: low ack in direction-line, high ready in strobe-pair
      if (s_mode == `HMI_MODE_DIR) begin
         next_ack = !(next_state == hmi_dev_ack);
      end else begin
         next_ack = !(next_state == hmi_dev_wait);
      end
   end
   // Register the sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= hmi_dev_idle;
         cnt <= '0;
         ack <= 1'b1;
         oe <= 1'b0;
         dout <= `HMI_RESET_BYTE;
         write_seen <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ack <= next_ack;
         oe <= next_oe;
         dout <= next_dout;
         write_seen <= next_write_seen;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Location file, one flip-flop byte per address
   logic [`HMI_DATA_W-1:0] next_locs [`HMI_LOCS];
   genvar gi;
   generate
      for (gi = 0; gi < `HMI_LOCS; gi++) begin : g_loc
         always_comb begin
            next_locs[gi] = locs[gi];
            if (wr_en && int'(addr2) == gi) begin
               next_locs[gi] = din2;
            end
         end
         // Register one location
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               locs[gi] <= `HMI_RESET_BYTE;
            end else begin
               locs[gi] <= next_locs[gi];
            end
         end
      end
   endgenerate
   // Control byte mirror for the user side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_byte <= `HMI_RESET_BYTE;
      end else begin
         ctrl_byte <= next_locs[`HMI_CTRL_ADDR];
      end
   end
   // Pin drives
   assign bus.host_acknowledge_pin = ack;
   assign bus.dev_data_oe = oe;
   assign bus.dev_data_out = dout;
endmodule
`default_nettype wire

// File: hw/hmi_host.sv
// Host end of the microport: turns user read/write requests into pin cycles.
// Assumes the device end on the same clock; the acknowledge passes two flops.
`timescale 1ns/10ps
`default_nettype none
`include "hmi_consts.svh"
module hmi_host
   import hmi_pkg::*;
#(
   parameter logic MODE = `HMI_MODE_PAIR
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins toward the device
   hmi_bus_if.host bus,
   // User request
   input wire logic req,
   input wire logic req_write,
   input wire logic [`HMI_ADDR_W-1:0] req_addr,
   input wire logic [`HMI_DATA_W-1:0] req_wdata,
   // User answer
   output logic busy,
   output logic done,
   output logic [`HMI_DATA_W-1:0] rdata
);
   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge and data synchronisers
   logic ack1, ack2;
   logic [`HMI_DATA_W-1:0] d1, d2;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack1 <= 1'b1;
         ack2 <= 1'b1;
         d1 <= '0;
         d2 <= '0;
      end else begin
         ack1 <= bus.host_acknowledge_pin;
         ack2 <= ack1;
         d1 <= bus.data_wire;
         d2 <= d1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Pin sequencer
   hmi_host_state_t state, next_state;
   logic cs_n, next_cs_n, stb, next_stb, dir, next_dir, oe, next_oe;
   logic is_wr, next_is_wr, next_busy, next_done;
   logic [`HMI_ADDR_W-1:0] a, next_a;
   logic [`HMI_DATA_W-1:0] wd, next_wd, next_rdata;
   logic complete;
   always_comb begin
      next_state = state;
      next_cs_n = cs_n;
      next_stb = stb;
      next_dir = dir;
      next_oe = oe;
      next_is_wr = is_wr;
      next_a = a;
      next_wd = wd;
      next_rdata = rdata;
      next_busy = busy;
      next_done = 1'b0;
      // Completion: low ack in direction-line; in strobe-pair ready high again
      complete = (MODE == `HMI_MODE_DIR) ? !ack2 : ack2;
      unique case (state)
         hmi_host_idle: begin
            if (req) begin
               next_a = req_addr;
               next_wd = req_wdata;
               next_is_wr = req_write;
               next_busy = 1'b1;
               next_cs_n = 1'b0;
               next_oe = req_write;
               next_dir = (MODE == `HMI_MODE_DIR) ? !req_write : 1'b1;
               next_state = hmi_host_setup;
            end
         end
         hmi_host_setup: begin
            if (MODE == `HMI_MODE_DIR) begin
               next_stb = 1'b0;
            end else if (is_wr) begin
               next_dir = 1'b0;
            end else begin
               next_stb = 1'b0;
            end
            next_state = hmi_host_strobe;
         end
         hmi_host_strobe: begin
            // A strobe-pair read waits here for the ready to fall, so that the
            // idle-high ready from before the device saw the strobe is not taken as done
            if (MODE == `HMI_MODE_DIR || is_wr || !ack2) begin
               next_state = hmi_host_hold;
            end
         end
         hmi_host_hold: begin
            if (complete || (MODE == `HMI_MODE_PAIR && is_wr && ack2)) begin
               next_rdata = is_wr ? rdata : d2;
               next_stb = 1'b1;
               next_dir = 1'b1;
               next_state = hmi_host_end;
            end
         end
         hmi_host_end: begin
            // Direction-line releases only after the device has seen the strobe end; strobe-pair releases at once
            if (MODE == `HMI_MODE_PAIR || ack2) begin
               next_cs_n = 1'b1;
               next_oe = 1'b0;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = hmi_host_idle;
            end
         end
         default: next_state = hmi_host_idle;
      endcase
   end
   // Register the sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= hmi_host_idle;
         cs_n <= 1'b1;
         stb <= 1'b1;
         dir <= 1'b1;
         oe <= 1'b0;
         is_wr <= 1'b0;
         a <= '0;
         wd <= '0;
         rdata <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         state <= next_state;
         cs_n <= next_cs_n;
         stb <= next_stb;
         dir <= next_dir;
         oe <= next_oe;
         is_wr <= next_is_wr;
         a <= next_a;
         wd <= next_wd;
         rdata <= next_rdata;
         busy <= next_busy;
         done <= next_done;
      end
   end
   // Pin drives
   assign bus.mode = MODE;
   assign bus.addr = a;
   assign bus.chip_sel_n = cs_n;
   assign bus.host_strobe_pin = stb;
   assign bus.dir_pin = dir;
   assign bus.host_data_out = wd;
   assign bus.host_data_oe = oe;
endmodule
`default_nettype wire

// File: testbench/hmi_bus_chk.sv
// Checker for one microport pin set, strobe-pair convention.
// Assumes the bench clock and reset, and a select code of zero while reads are timed.
`timescale 1ns/10ps
`default_nettype none
module hmi_bus_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host-driven pins
   input wire logic mode,
   input wire logic [2:0] addr,
   input wire logic [3:0] device_select_code,
   input wire logic chip_sel_n,
   input wire logic host_strobe_pin,
   input wire logic dir_pin,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   // Device-driven pins
   input wire logic host_acknowledge_pin,
   input wire logic [7:0] dev_data_out,
   input wire logic dev_data_oe,
   input wire logic [7:0] data_wire
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // Read start and answer steps
   sequence s_rd_start;
      !chip_sel_n && $fell(host_strobe_pin) && dir_pin && !mode && device_select_code == 4'h0;
   endsequence
   sequence s_rd_answer;
      ##[1:13] dev_data_oe;
   endsequence
   property p_rd_time;
      s_rd_start |-> s_rd_answer;
   endproperty
   a_rd_time: assert property (p_rd_time)
      else $error("read not answered in time");
   property p_release;
      chip_sel_n [*4] |-> !dev_data_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("data bus driven while deselected");
   property p_no_fight;
      dev_data_oe |-> !host_data_oe;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the data bus");
   property p_dout_hold;
      dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_out);
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("read data changed while driven");
   property p_oe_ends;
      $rose(host_strobe_pin) |-> ##[0:5] !dev_data_oe;
   endproperty
   a_oe_ends: assert property (p_oe_ends)
      else $error("data bus held after strobe end");
   property p_mode_static;
      $stable(mode);
   endproperty
   a_mode_static: assert property (p_mode_static)
      else $error("mode pin changed");
   property p_ready_idle;
      chip_sel_n [*4] |-> host_acknowledge_pin;
   endproperty
   a_ready_idle: assert property (p_ready_idle)
      else $error("ready low while idle");
   property p_ready_back;
      $rose(dev_data_oe) |-> ##[0:2] host_acknowledge_pin;
   endproperty
   a_ready_back: assert property (p_ready_back)
      else $error("ready not restored with data");
   property p_wr_data;
      !dir_pin && !chip_sel_n && !mode |-> host_data_oe;
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write strobe without host data");
   property p_rd_no_host;
      !host_strobe_pin && !mode |-> !host_data_oe;
   endproperty
   a_rd_no_host: assert property (p_rd_no_host)
      else $error("host drives bus during read strobe");
endmodule
`default_nettype wire

// File: testbench/tb_host_microport_interface.sv
// Bench: both conventions side by side, fed the same user requests.
// Assumes the design files and hmi_consts.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "hmi_consts.svh"
module tb_host_microport_interface;
   typedef struct {logic [2:0] a; logic [7:0] d;} hmi_row_t;
   logic clk, rst_n, req, req_write;
   logic [2:0] req_addr;
   logic [7:0] req_wdata, rdata_p, rdata_d, ctrl_p, ctrl_d;
   logic busy_p, busy_d, done_p, done_d, seen_p, seen_d;
   logic [3:0] sel;
   logic [7:0] nwr = 8'h00;
   logic [7:0] nwr_d = 8'h00;
   int failures = 0;
   int cmp_count = 0;
   hmi_row_t rows [8] = '{'{3'h0, 8'h5a}, '{3'h1, 8'ha5}, '{3'h2, 8'hff}, '{3'h3, 8'h01},
      '{3'h4, 8'h80}, '{3'h5, 8'h3c}, '{3'h6, 8'h66}, '{3'h7, 8'hc3}};
   ////////////////////////////////////////////////////////////////
   // Two pin sets, one per convention
   hmi_bus_if bus_p();
   hmi_bus_if bus_d();
   assign bus_p.device_select_code = sel;
   assign bus_d.device_select_code = sel;
   hmi_host #(.MODE(`HMI_MODE_PAIR)) hmi_host_i (.clk(clk), .rst_n(rst_n), .bus(bus_p),
      .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy(busy_p), .done(done_p), .rdata(rdata_p));
   hmi_device hmi_device_i (.clk(clk), .rst_n(rst_n), .bus(bus_p), .ctrl_byte(ctrl_p),
      .write_seen(seen_p));
   hmi_host #(.MODE(`HMI_MODE_DIR)) hmi_host_dir_i (.clk(clk), .rst_n(rst_n), .bus(bus_d),
      .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy(busy_d), .done(done_d), .rdata(rdata_d));
   hmi_device hmi_device_dir_i (.clk(clk), .rst_n(rst_n), .bus(bus_d), .ctrl_byte(ctrl_d),
      .write_seen(seen_d));
   hmi_bus_chk hmi_bus_chk_i (.clk(clk), .rst_n(rst_n), .mode(bus_p.mode), .addr(bus_p.addr),
      .device_select_code(bus_p.device_select_code), .chip_sel_n(bus_p.chip_sel_n),
      .host_strobe_pin(bus_p.host_strobe_pin), .dir_pin(bus_p.dir_pin),
      .host_data_out(bus_p.host_data_out), .host_data_oe(bus_p.host_data_oe),
      .host_acknowledge_pin(bus_p.host_acknowledge_pin), .dev_data_out(bus_p.dev_data_out),
      .dev_data_oe(bus_p.dev_data_oe), .data_wire(bus_p.data_wire));
   // Clock and write counter
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (seen_p === 1'b1) nwr <= nwr + 8'h01;
      if (seen_d === 1'b1) nwr_d <= nwr_d + 8'h01;
   end
   ////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One access on both hosts; dup offers a second request while busy
   task automatic go(input logic w, input logic [2:0] a, input logic [7:0] d, input logic dup);
      int n;
      logic gp, gd;
      gp = 1'b0;
      gd = 1'b0;
      @(posedge clk);
      #1;
      req = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(posedge clk);
      #1;
      // Both hosts have taken the request at this edge
      chk({7'h00, busy_p}, 8'h01);
      chk({7'h00, busy_d}, 8'h01);
      if (dup) begin
         req_addr = a + 3'h1;
         req_wdata = ~d;
         @(posedge clk);
         #1;
      end
      req = 1'b0;
      for (n = 0; n < 300; n++) begin
         if (done_p === 1'b1) gp = 1'b1;
         if (done_d === 1'b1) gd = 1'b1;
         if (gp && gd) break;
         @(posedge clk);
         #1;
      end
      if (!(gp && gd)) begin
         failures++;
         $display("FAIL %0t access never completed", $time);
         end_sim;
      end else begin
         // Both hosts free again once their done has been seen
         chk({7'h00, busy_p}, 8'h00);
         chk({7'h00, busy_d}, 8'h00);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_addr = 3'h0;
      req_wdata = 8'h00;
      sel = 4'h0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      chk(bus_p.data_wire, 8'hff);
      chk(bus_d.data_wire, 8'hff);
      foreach (rows[i]) go(1'b1, rows[i].a, rows[i].d, 1'b0);
      foreach (rows[i]) begin
         go(1'b0, rows[i].a, 8'h00, 1'b0);
         chk(rdata_p, rows[i].d);
         chk(rdata_d, rows[i].d);
      end
      chk(ctrl_p, 8'hc3);
      $display("table done");
      go(1'b1, 3'h1, 8'h77, 1'b1);
      go(1'b0, 3'h2, 8'h00, 1'b0);
      chk(rdata_p, 8'hff);
      chk(rdata_d, 8'hff);
      go(1'b0, 3'h1, 8'h00, 1'b0);
      chk(rdata_d, 8'h77);
      chk(rdata_p, 8'h77);
      $display("busy request done");
      go(1'b1, 3'h7, 8'h14, 1'b0);
      sel = 4'h5;
      go(1'b0, 3'h0, 8'h00, 1'b0);
      chk(rdata_p, 8'h5a);
      chk(rdata_d, 8'h5a);
      chk(ctrl_d, 8'h14);
      chk(nwr, 8'h0a);
      chk(nwr_d, 8'h0a);
      $display("select done");
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      sel = 4'h0;
      chk(ctrl_p, 8'h00);
      go(1'b0, 3'h0, 8'h00, 1'b0);
      chk(rdata_p, 8'h00);
      chk(rdata_d, 8'h00);
      $display("reset done");
      end_sim;
   end
endmodule
`default_nettype wire
